// ==== design/tmr_cnt_pkg.sv ====
// Constants, register map and BCD helpers shared by the timer and counter logic.
package tmr_cnt_pkg;
  // ==========================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CENTI_TIME_NS = 10_000_000;
  localparam int unsigned CENTI_CYCLES = CENTI_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] STEP_LAST = 4'h9;
  // ==========================================================
  // Fixed timer slots and adjustment limits.
  localparam logic [3:0] SLOT_SINGLE = 4'hf;
  localparam logic [3:0] SLOT_RANGED_ONE = 4'hb;
  localparam logic [3:0] SLOT_RANGED_TWO = 4'hc;
  localparam logic [7:0] ADJ_MIN = 8'h01;
  localparam logic [7:0] ADJ_MAX = 8'hfa;
  // ==========================================================
  // Register addresses.
  localparam logic [7:0] ADDR_SCAN = 8'h00;
  localparam logic [7:0] ADDR_RANGE_ONE = 8'h01;
  localparam logic [7:0] ADDR_RANGE_TWO = 8'h02;
  localparam logic [7:0] ADDR_CNT_PRESET = 8'h03;
  localparam logic [7:0] ADDR_CNT_SLOT = 8'h04;
  localparam logic [7:0] ADDR_ADJ_WORD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h09;
  localparam logic [7:0] ADDR_DONE_MAP = 8'h0a;
  localparam logic [7:0] ADDR_CNT_PV = 8'h0b;
  localparam logic [7:0] ADDR_TIMER_PV = 8'h0c;
  // ==========================================================
  // Field positions and reset values.
  localparam int COND_SINGLE = 0;
  localparam int COND_RANGED_ONE = 1;
  localparam int COND_RANGED_TWO = 2;
  localparam int COND_INTERLOCK = 3;
  localparam int COND_COUNT = 4;
  localparam int COND_RESET = 5;
  localparam int FROM_WORD = 16;
  localparam int ST_ERROR = 0;
  localparam int ST_FIRST_SCAN = 1;
  localparam logic [15:0] RANGE_CODE_SEC = 16'h0000;
  localparam logic [15:0] RANGE_CODE_DECI = 16'h0001;
  localparam logic [15:0] RANGE_CODE_CENTI = 16'h0002;
  localparam logic [16:0] RANGE_RESET = 17'h00001;
  localparam logic [16:0] CNT_PRESET_RESET = 17'h00000;
  localparam logic [3:0] CNT_SLOT_RESET = 4'h0;

  // True when all four digits are decimal.
  function automatic logic bcd_valid(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*4+:4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : bcd_valid

  // Three-digit BCD of a binary value up to 255.
  function automatic logic [11:0] bin_to_bcd3(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / 8'h64;
    t = (v % 8'h64) / 8'h0a;
    o = v % 8'h0a;
    return {h[3:0], t[3:0], o[3:0]};
  endfunction : bin_to_bcd3

  // Four-digit BCD minus one, digit by digit with borrow.
  function automatic logic [15:0] bcd_dec4(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4+:4] == 4'h0) begin
          r[i*4+:4] = 4'h9;
        end else begin
          r[i*4+:4] = r[i*4+:4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec4
endpackage : tmr_cnt_pkg

// ==== design/analog_timer.sv ====
// One down-running analog timer with preset load and completion flag.
`timescale 1ns/100ps
module analog_timer (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic exec_on,
  input wire logic clear,
  input wire logic [7:0] preset,
  output logic [7:0] pv,
  output logic done
);
  import tmr_cnt_pkg::*;

  logic [7:0] pv_q;
  logic done_q;

  // Load while idle or cleared, run down on base ticks, flag at zero.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pv_q <= 8'h00;
      done_q <= 1'b0;
    end else if (clear || !exec_on) begin
      pv_q <= preset;
      done_q <= 1'b0;
    end else if (pv_q == 8'h00) begin
      done_q <= 1'b1;
    end else if (tick) begin
      pv_q <= pv_q - 8'h01;
      done_q <= (pv_q == 8'h01);
    end
  end

  assign pv = pv_q;
  assign done = done_q;

  chk_timer_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clear || !exec_on) |=> (pv_q == $past(preset)) && !done_q)
    else $error("timer did not reload when idle or cleared");
  chk_timer_done: assert property (@(posedge core_clk) disable iff (!resetn)
    done_q |-> (pv_q == 8'h00))
    else $error("timer done with nonzero value");
endmodule : analog_timer

// ==== design/preset_down_counter.sv ====
// Scan-evaluated BCD down counter with edge count and level reset.
`timescale 1ns/100ps
module preset_down_counter (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scan,
  input wire logic count_in,
  input wire logic reset_in,
  input wire logic [15:0] preset,
  output logic [15:0] pv,
  output logic done
);
  import tmr_cnt_pkg::*;

  logic [15:0] pv_q;
  logic done_q;
  logic prev_cp_q;
  logic prev_rst_q;
  logic rise_cp;

  assign rise_cp = count_in && !prev_cp_q;

  // Inputs seen at the previous execution, for edge detection.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_cp_q <= 1'b0;
      prev_rst_q <= 1'b0;
    end else if (scan) begin
      prev_cp_q <= count_in;
      prev_rst_q <= reset_in;
    end
  end

  // Count state changes only at an execution.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pv_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (scan) begin
      if (reset_in) begin
        done_q <= 1'b0;
        if (!prev_rst_q) pv_q <= preset;
      end else if (rise_cp && pv_q != 16'h0000) begin
        pv_q <= bcd_dec4(pv_q);
        if (bcd_dec4(pv_q) == 16'h0000) done_q <= 1'b1;
      end
    end
  end

  assign pv = pv_q;
  assign done = done_q;

  chk_edge_decrement: assert property (@(posedge core_clk) disable iff (!resetn)
    (scan && !reset_in && rise_cp && pv_q != 16'h0000) |=> pv_q == bcd_dec4($past(pv_q)))
    else $error("counter missed a rising count edge");
  chk_hold_steady: assert property (@(posedge core_clk) disable iff (!resetn)
    (!scan || (!reset_in && !rise_cp)) |=> $stable(pv_q))
    else $error("counter changed without a rising edge");
  chk_reset_reload: assert property (@(posedge core_clk) disable iff (!resetn)
    (scan && reset_in && !prev_rst_q) |=> pv_q == $past(preset) && !done_q)
    else $error("counter did not reload on reset edge");
  chk_done_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (done_q && !(scan && reset_in)) |=> done_q)
    else $error("counter done dropped before reset");
endmodule : preset_down_counter

// ==== design/analog_timer_down_counter.sv ====
// Top of the analog timers and preset counter with register port.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Single timer preset from adjustment, BCD stored
// - Single timer preset 0.1 to 25.0 s
// - Single timer always at slot 15
// - Ranged timers fixed at slots 11, 12
// - Adjustment BCD placed in dedicated word 08
// - Range code picks 1 s, 0.1 s, 0.01 s
// - Ranged timers take range code, never preset
// - Range code immediate or from a word
// - Adjustment one shared, adjustment two separate
// - Timers clear on interlock off or power loss
// - Non-BCD range word sets error, still runs
// - Counter decrements on rising count input
// - Steady or falling input leaves counter unchanged
// - Counter done at zero until reset
// - Reset edge reloads; no counting while reset
// - Counter keeps value through interlock, power loss
// - Non-BCD preset word sets error, still runs
// - First-scan flag usable as counter reset
// - Centisecond time base of 0.01 s
module analog_timer_down_counter #(
  parameter int unsigned CENTI_CYC = tmr_cnt_pkg::CENTI_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] adj_one_raw,
  input wire logic [7:0] adj_two_raw,
  input wire logic power_fail,
  output logic [15:0] done_map,
  output logic error_flag,
  output logic first_scan_flag
);
  import tmr_cnt_pkg::*;

  // ==========================================================
  // Pin synchronisers.
  logic [7:0] adj_one_s1_q;
  logic [7:0] adj_one_s2_q;
  logic [7:0] adj_two_s1_q;
  logic [7:0] adj_two_s2_q;
  logic pwr_s1_q;
  logic pwr_s2_q;

  // The knobs move slowly, so a per-bit synchroniser is enough; a reading
  // caught mid-change is corrected at the next edge.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      adj_one_s1_q <= 8'h00;
      adj_one_s2_q <= 8'h00;
      adj_two_s1_q <= 8'h00;
      adj_two_s2_q <= 8'h00;
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end else begin
      adj_one_s1_q <= adj_one_raw;
      adj_one_s2_q <= adj_one_s1_q;
      adj_two_s1_q <= adj_two_raw;
      adj_two_s2_q <= adj_two_s1_q;
      pwr_s1_q <= power_fail;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  // ==========================================================
  // Adjustment readings, clamped and converted.
  logic [7:0] adj_one_val;
  logic [7:0] adj_two_val;
  logic [31:0] adj_word_q;

  // Clamp into 1..250 steps so no range can yield a zero preset.
  assign adj_one_val = (adj_one_s2_q < ADJ_MIN) ? ADJ_MIN :
                       (adj_one_s2_q > ADJ_MAX) ? ADJ_MAX : adj_one_s2_q;
  assign adj_two_val = (adj_two_s2_q < ADJ_MIN) ? ADJ_MIN :
                       (adj_two_s2_q > ADJ_MAX) ? ADJ_MAX : adj_two_s2_q;

  // Dedicated word 08 holds both settings in BCD.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      adj_word_q <= 32'h0000_0000;
    end else begin
      adj_word_q <= {4'h0, bin_to_bcd3(adj_two_val),
                     4'h0, bin_to_bcd3(adj_one_val)};
    end
  end

  // ==========================================================
  // Time base.
  logic [20:0] centi_cnt_q;
  logic [3:0] deci_cnt_q;
  logic [3:0] sec_cnt_q;
  logic tick_centi;
  logic tick_deci;
  logic tick_sec;

  assign tick_centi = (centi_cnt_q == 21'(CENTI_CYC - 1));
  assign tick_deci = tick_centi && (deci_cnt_q == STEP_LAST);
  assign tick_sec = tick_deci && (sec_cnt_q == STEP_LAST);

  // Cascaded dividers: 0.01 s, then tenths, then seconds.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      centi_cnt_q <= 21'h000000;
      deci_cnt_q <= 4'h0;
      sec_cnt_q <= 4'h0;
    end else begin
      centi_cnt_q <= tick_centi ? 21'h000000 : centi_cnt_q + 21'h000001;
      if (tick_centi) deci_cnt_q <= tick_deci ? 4'h0 : deci_cnt_q + 4'h1;
      if (tick_deci) sec_cnt_q <= tick_sec ? 4'h0 : sec_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // Registers written by software.
  logic [5:0] cond_q;
  logic scan_q;
  logic [16:0] range_one_q;
  logic [16:0] range_two_q;
  logic [16:0] cnt_preset_q;
  logic [3:0] cnt_slot_q;
  logic wr_scan;

  assign wr_scan = reg_wr && (reg_addr == ADDR_SCAN);

  // A scan write latches the execution conditions and fires one execution.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cond_q <= 6'h00;
      scan_q <= 1'b0;
    end else begin
      scan_q <= wr_scan;
      if (wr_scan) cond_q <= reg_wdata[5:0];
    end
  end

  // Only range codes are writable for the ranged timers; there is no preset
  // register for them at all, and the source bit marks a word operand.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      range_one_q <= RANGE_RESET;
      range_two_q <= RANGE_RESET;
      cnt_preset_q <= CNT_PRESET_RESET;
      cnt_slot_q <= CNT_SLOT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_RANGE_ONE) range_one_q <= reg_wdata[16:0];
      if (reg_addr == ADDR_RANGE_TWO) range_two_q <= reg_wdata[16:0];
      if (reg_addr == ADDR_CNT_PRESET) cnt_preset_q <= reg_wdata[16:0];
      if (reg_addr == ADDR_CNT_SLOT) cnt_slot_q <= reg_wdata[3:0];
    end
  end

  // ==========================================================
  // Timer controls.
  logic interlock_on;
  logic timer_clear;
  logic tick_one;
  logic tick_two;
  logic [7:0] pv_single;
  logic [7:0] pv_one;
  logic [7:0] pv_two;
  logic done_single;
  logic done_one;
  logic done_two;

  assign interlock_on = cond_q[COND_INTERLOCK];
  assign timer_clear = !interlock_on || pwr_s2_q;

  // Unknown range codes fall back to whole seconds.
  assign tick_one = (range_one_q[15:0] == RANGE_CODE_DECI) ? tick_deci :
                    (range_one_q[15:0] == RANGE_CODE_CENTI) ? tick_centi : tick_sec;
  assign tick_two = (range_two_q[15:0] == RANGE_CODE_DECI) ? tick_deci :
                    (range_two_q[15:0] == RANGE_CODE_CENTI) ? tick_centi : tick_sec;

  // Single timer: tenths of a second from adjustment one.
  analog_timer u_single_analog_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick_deci),
    .exec_on(cond_q[COND_SINGLE]),
    .clear(timer_clear),
    .preset(adj_one_val),
    .pv(pv_single),
    .done(done_single)
  );

  // First ranged timer shares adjustment one with the single timer.
  analog_timer u_ranged_analog_timer_one (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick_one),
    .exec_on(cond_q[COND_RANGED_ONE]),
    .clear(timer_clear),
    .preset(adj_one_val),
    .pv(pv_one),
    .done(done_one)
  );

  // Second ranged timer runs from its own adjustment.
  analog_timer u_ranged_analog_timer_two (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick_two),
    .exec_on(cond_q[COND_RANGED_TWO]),
    .clear(timer_clear),
    .preset(adj_two_val),
    .pv(pv_two),
    .done(done_two)
  );

  // ==========================================================
  // Counter.
  logic [15:0] cnt_pv;
  logic cnt_done;
  logic cnt_scan;

  // Interlock only suspends execution; neither it nor a power loss touches
  // the counter value.
  assign cnt_scan = scan_q && interlock_on;

  preset_down_counter u_preset_down_counter (
    .core_clk(core_clk),
    .resetn(resetn),
    .scan(cnt_scan),
    .count_in(cond_q[COND_COUNT]),
    .reset_in(cond_q[COND_RESET]),
    .preset(cnt_preset_q[15:0]),
    .pv(cnt_pv),
    .done(cnt_done)
  );

  // ==========================================================
  // Flags.
  logic error_q;
  logic first_scan_q;
  logic err_event;
  logic err_clear;

  // Only word operands are checked; an immediate code is trusted.
  assign err_event = scan_q && (
    (range_one_q[FROM_WORD] && !bcd_valid(range_one_q[15:0])) ||
    (range_two_q[FROM_WORD] && !bcd_valid(range_two_q[15:0])) ||
    (cnt_preset_q[FROM_WORD] && !bcd_valid(cnt_preset_q[15:0])));
  assign err_clear = reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[ST_ERROR];

  // Error is sticky; a new event in the clearing cycle wins.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      error_q <= 1'b0;
    end else if (err_event) begin
      error_q <= 1'b1;
    end else if (err_clear) begin
      error_q <= 1'b0;
    end
  end

  // First-scan flag stands from reset until the first execution ends.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      first_scan_q <= 1'b1;
    end else if (scan_q) begin
      first_scan_q <= 1'b0;
    end
  end

  // ==========================================================
  // Completion map by slot.
  logic [15:0] done_map_q;
  logic [15:0] done_map_d;

  always_comb begin
    done_map_d = 16'h0000;
    done_map_d[cnt_slot_q] = cnt_done;
    done_map_d[SLOT_RANGED_ONE] = done_one;
    done_map_d[SLOT_RANGED_TWO] = done_two;
    done_map_d[SLOT_SINGLE] = done_single;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done_map_q <= 16'h0000;
    end else begin
      done_map_q <= done_map_d;
    end
  end

  // ==========================================================
  // Read port.
  logic [31:0] rdata_q;

  // Unmapped addresses read as zero, one cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SCAN: rdata_q <= {26'h0000000, cond_q};
        ADDR_RANGE_ONE: rdata_q <= {15'h0000, range_one_q};
        ADDR_RANGE_TWO: rdata_q <= {15'h0000, range_two_q};
        ADDR_CNT_PRESET: rdata_q <= {15'h0000, cnt_preset_q};
        ADDR_CNT_SLOT: rdata_q <= {28'h0000000, cnt_slot_q};
        ADDR_ADJ_WORD: rdata_q <= adj_word_q;
        ADDR_STATUS: rdata_q <= {30'h00000000, first_scan_q, error_q};
        ADDR_DONE_MAP: rdata_q <= {16'h0000, done_map_q};
        ADDR_CNT_PV: rdata_q <= {16'h0000, cnt_pv};
        ADDR_TIMER_PV: rdata_q <= {8'h00, pv_two, pv_one, pv_single};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign done_map = done_map_q;
  assign error_flag = error_q;
  assign first_scan_flag = first_scan_q;

  // ==========================================================
  // Checks.
  chk_error_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    err_event |=> error_q)
    else $error("error flag not set by bad BCD word");
  chk_first_scan_drop: assert property (@(posedge core_clk) disable iff (!resetn)
    scan_q |=> !first_scan_q ##1 !first_scan_q)
    else $error("first-scan flag survived an execution");
  chk_slot_single: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 done_map_q[SLOT_SINGLE] == $past(done_single))
    else $error("single timer not reported at slot 15");
  chk_shared_adjust: assert property (@(posedge core_clk) disable iff (!resetn)
    $stable(adj_one_s2_q) && $stable(adj_two_s2_q) |=>
      adj_word_q[11:0] == bin_to_bcd3($past(adj_one_val)) &&
      adj_word_q[27:16] == bin_to_bcd3($past(adj_two_val)))
    else $error("word 08 does not follow the adjustments");
  chk_counter_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
    (timer_clear && !cnt_scan) |=> $stable(cnt_pv))
    else $error("counter value lost on clear");
endmodule : analog_timer_down_counter

// ==== testbench/scan_program.sv ====
// Model of the control program that hands execution conditions over each scan.
`timescale 1ns/100ps
module scan_program (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic first_scan_flag
);
  import tmr_cnt_pkg::*;
  // ==========================================================
  // Bus cycles.
  // Idle values from time zero so no strobe ever floats.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write cycle; the strobe drops at the edge that takes it.
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : write_reg

  // The data stand only in the cycle after the strobe, so take them at its closing edge.
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : read_reg

  // ==========================================================
  // Program behaviour.
  // The first-scan flag is ORed into the counter reset, so a cold start begins at the preset.
  task automatic run_scan(input logic [5:0] c);
    logic [5:0] s;
    s = c;
    if (first_scan_flag === 1'b1) s[COND_RESET] = 1'b1;
    write_reg(ADDR_SCAN, {26'h0, s});
  endtask : run_scan

  // The counter never takes a slot owned by a dedicated timer, so each slot has one user.
  task automatic set_slot(input logic [3:0] n);
    write_reg(ADDR_CNT_SLOT, {28'h0, (n >= SLOT_RANGED_ONE) ? 4'h0 : n});
  endtask : set_slot
endmodule : scan_program

// ==== testbench/tb.sv ====
// Self-checking bench for the analog timers and the preset down counter.
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import tmr_cnt_pkg::*;
  localparam int unsigned CENTI = 10;
  localparam int LIMIT = 10000;
  logic core_clk = 1'b0;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0] adj_one_raw;
  logic [7:0] adj_two_raw;
  logic power_fail;
  logic [15:0] done_map;
  logic error_flag;
  logic first_scan_flag;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [5:0] seq_c [15] = '{6'h08, 6'h18, 6'h18, 6'h08, 6'h18, 6'h10, 6'h18, 6'h08,
    6'h18, 6'h08, 6'h28, 6'h38, 6'h18, 6'h08, 6'h18};
  logic [15:0] seq_pv [15] = '{16'h3, 16'h2, 16'h2, 16'h2, 16'h1, 16'h1, 16'h1, 16'h1,
    16'h0, 16'h0, 16'h3, 16'h3, 16'h3, 16'h3, 16'h2};

  // ==========================================================
  // Clock, design and program model.
  // The short tick parameter keeps second-range runs within a few thousand cycles.
  always #4 core_clk = ~core_clk;
  analog_timer_down_counter #(.CENTI_CYC(CENTI)) uut (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .adj_one_raw(adj_one_raw),
    .adj_two_raw(adj_two_raw),
    .power_fail(power_fail),
    .done_map(done_map),
    .error_flag(error_flag),
    .first_scan_flag(first_scan_flag)
  );
  scan_program prog (
    .core_clk(core_clk),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .first_scan_flag(first_scan_flag)
  );

  // ==========================================================
  // Helpers and verdict.
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    prog.read_reg(a, d);
    `CHK(d, e)
  endtask : expect_reg

  // Lets a scan pulse and the flag registers behind it land before looking.
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask : settle

  // A hung wait ends the run as a failure instead of spinning forever.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence.
  initial begin
    resetn = 1'b0;
    adj_one_raw = 8'h00;
    adj_two_raw = 8'hc8;
    power_fail = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    `CHK(first_scan_flag, 1'b1)
    `CHK(done_map, 16'h0000)
    settle();
    expect_reg(ADDR_RANGE_ONE, 32'h0000_0001);
    expect_reg(8'h20, 32'h0000_0000);
    expect_reg(ADDR_ADJ_WORD, 32'h0200_0001);
    adj_one_raw <= 8'hff;
    settle();
    expect_reg(ADDR_ADJ_WORD, 32'h0200_0250);
    // Counter walk: edges, steady and falling input, interlock off, reset edge.
    prog.write_reg(ADDR_CNT_PRESET, 32'h0000_0003);
    prog.set_slot(4'h4);
    prog.run_scan(6'h28);
    expect_reg(ADDR_CNT_PV, 32'h0000_0003);
    `CHK(first_scan_flag, 1'b0)
    for (int i = 0; i < 15; i++) begin
      prog.run_scan(seq_c[i]);
      expect_reg(ADDR_CNT_PV, {16'h0, seq_pv[i]});
      if (i == 9) `CHK(done_map[4], 1'b1)
    end
    `CHK(done_map[4], 1'b0)
    power_fail <= 1'b1;
    settle();
    power_fail <= 1'b0;
    settle();
    expect_reg(ADDR_CNT_PV, 32'h0000_0002);
    prog.write_reg(ADDR_CNT_PRESET, 32'h0000_0100);
    prog.run_scan(6'h28);
    prog.run_scan(6'h18);
    expect_reg(ADDR_CNT_PV, 32'h0000_0099);
    // Error flag from non-decimal words only.
    prog.write_reg(ADDR_CNT_PRESET, 32'h0001_1a00);
    prog.run_scan(6'h08);
    settle();
    `CHK(error_flag, 1'b1)
    prog.write_reg(ADDR_CNT_PRESET, 32'h0000_0100);
    prog.write_reg(ADDR_STATUS, 32'h0000_0001);
    prog.write_reg(ADDR_RANGE_ONE, 32'h0000_000a);
    prog.run_scan(6'h08);
    settle();
    `CHK(error_flag, 1'b0)
    prog.write_reg(ADDR_RANGE_ONE, 32'h0001_000a);
    prog.run_scan(6'h08);
    settle();
    `CHK(error_flag, 1'b1)
    prog.write_reg(ADDR_STATUS, 32'h0000_0001);
    // Timers: shared and separate adjustments, fixed slots, centi range.
    adj_one_raw <= 8'h03;
    adj_two_raw <= 8'h02;
    prog.write_reg(ADDR_RANGE_ONE, 32'h0000_0002);
    prog.write_reg(ADDR_RANGE_TWO, 32'h0000_0002);
    prog.run_scan(6'h08);
    settle();
    expect_reg(ADDR_TIMER_PV, 32'h0002_0303);
    prog.write_reg(ADDR_TIMER_PV, 32'h0000_0000);
    expect_reg(ADDR_TIMER_PV, 32'h0002_0303);
    prog.run_scan(6'h0f);
    repeat (45) @(posedge core_clk);
    `CHK(done_map[12:11], 2'b11)
    `CHK(done_map[15], 1'b0)
    repeat (300) @(posedge core_clk);
    `CHK(done_map[15], 1'b1)
    prog.run_scan(6'h07);
    settle();
    `CHK({done_map[15], done_map[12:11]}, 3'b000)
    expect_reg(ADDR_TIMER_PV, 32'h0002_0303);
    expect_reg(ADDR_CNT_PV, 32'h0000_0099);
    // Deci and second ranges, then a power loss while both are done.
    prog.write_reg(ADDR_RANGE_ONE, 32'h0000_0001);
    prog.write_reg(ADDR_RANGE_TWO, 32'h0001_0000);
    prog.run_scan(6'h0e);
    repeat (150) @(posedge core_clk);
    `CHK(done_map[12:11], 2'b00)
    repeat (200) @(posedge core_clk);
    `CHK(done_map[12:11], 2'b01)
    repeat (1700) @(posedge core_clk);
    `CHK(done_map[12:11], 2'b11)
    `CHK(error_flag, 1'b0)
    power_fail <= 1'b1;
    // Two sync stages, the clear and the map register: look one edge after the map settles.
    repeat (5) @(posedge core_clk);
    `CHK(done_map[12:11], 2'b00)
    power_fail <= 1'b0;
    complete_run();
  end
endmodule : tb
